/* core/tlc_adc_ctrl.sv */
// Contract
// - limits are 8-bit codes, 4 mV per count
// - cold limit resets to 0x91
// - cool limit code zero disables cool check
// - cool limit resets to zero, least 4 mV
// - warm limit resets to zero, least 4 mV
// - hot limit resets to 0x45
// - converter on-bit gates conversion; register/watchdog clear it
// - rate 00 continuous, 01 single conversion
// - rate 10 every second, 11 every minute
// - sample code 00 gives 11, 01 gives 10 bits
// - codes 10/11 give 9 bits, reset 10
// - averaging off keeps latest, on keeps average
// - seed bit 0 starts from existing result
// - seed bit 1 starts from fresh conversion
// - main control resets to 0x10
// - comparator setup resets to 0xc8
// - channel select codes map to eight measurements
// - aux bias select enables 80 uA source
// - bus idle 15 s after power requests reset
module tlc_adc_ctrl #(
  parameter int unsigned SEC_CYCLES = tlc_pkg::CYCLES_PER_SEC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register port from the serial bus target
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic [7:0]       regRdData_q,
  // system events
  input  wire logic        regReset,
  input  wire logic        busTransaction,
  input  wire logic        busIdleGuardOn,
  input  wire logic        inputPowerPresent,
  output logic             hwResetRequest_q,
  // converter
  output logic             adcPowerOn_q,
  output logic             convStart_q,
  input  wire logic        convDone,
  input  wire logic [15:0] convData,
  output logic [3:0]       effResolution_q,
  // comparators and aux input
  output logic             comparatorOneOn_q,
  output logic             comparatorTwoOn_q,
  output logic             comparatorThreeOn_q,
  output logic [2:0]       comparatorOneChannel_q,
  output logic             auxInputBiasOn_q,
  // thermistor result and zone
  output logic [15:0]      thermistorResult_q,
  output logic             resultValid_q,
  output logic             zoneCold_q,
  output logic             zoneCool_q,
  output logic             zoneWarm_q,
  output logic             zoneHot_q
);

  logic [7:0] coldLimit_q;
  logic [7:0] coolLimit_q;
  logic [7:0] warmLimit_q;
  logic [7:0] hotLimit_q;
  logic [7:0] ctrlMain_q;
  logic [7:0] compSetup_q;
  logic       guardServed_q;

  tlc_pkg::tlc_sched_type state_q;
  tlc_pkg::tlc_sched_type state_d;

  // write decode
  wire wrCold  = regWrEn && (regAddr == tlc_pkg::COLD_LIMIT_ADDR);
  wire wrCool  = regWrEn && (regAddr == tlc_pkg::COOL_LIMIT_ADDR);
  wire wrWarm  = regWrEn && (regAddr == tlc_pkg::WARM_LIMIT_ADDR);
  wire wrHot   = regWrEn && (regAddr == tlc_pkg::HOT_LIMIT_ADDR);
  wire wrMain  = regWrEn && (regAddr == tlc_pkg::CTRL_MAIN_ADDR);
  wire wrComp  = regWrEn && (regAddr == tlc_pkg::COMP_SETUP_ADDR);

  // field views
  wire       adcOn       = ctrlMain_q[tlc_pkg::ADC_ON_BIT];
  wire [1:0] rateSel     = ctrlMain_q[tlc_pkg::RATE_LSB +: 2];
  wire [1:0] sampleSel   = ctrlMain_q[tlc_pkg::SAMPLE_LSB +: 2];
  wire       averagingOn = ctrlMain_q[tlc_pkg::AVERAGING_BIT];
  wire       seedSelect  = ctrlMain_q[tlc_pkg::SEED_SELECT_BIT];

  // reserved bit 0 reads zero and ignores writes
  wire [7:0] mainWrMasked = {regWrData[7:1], 1'b0};
  wire [7:0] compWrMasked = {regWrData[7:1], 1'b0};

  // read mux, unmapped offsets read zero
  wire [7:0] rdMux =
    (regAddr == tlc_pkg::COLD_LIMIT_ADDR) ? coldLimit_q :
    (regAddr == tlc_pkg::COOL_LIMIT_ADDR) ? coolLimit_q :
    (regAddr == tlc_pkg::WARM_LIMIT_ADDR) ? warmLimit_q :
    (regAddr == tlc_pkg::HOT_LIMIT_ADDR)  ? hotLimit_q  :
    (regAddr == tlc_pkg::CTRL_MAIN_ADDR)  ? ctrlMain_q  :
    (regAddr == tlc_pkg::COMP_SETUP_ADDR) ? compSetup_q : 8'h00;

  // time bases
  logic secTick;
  logic minTick;
  logic guardTick;

  wire guardArmed = busIdleGuardOn && inputPowerPresent && !guardServed_q;

  tlc_tick_divider #(.DIV(SEC_CYCLES)) u_sec_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .en       (1'b1),
    .clr      (!adcOn && !guardArmed),
    .tick     (secTick)
  );

  tlc_tick_divider #(.DIV(tlc_pkg::MINUTE_S)) u_min_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .en       (secTick),
    .clr      (!adcOn),
    .tick     (minTick)
  );

  tlc_tick_divider #(.DIV(tlc_pkg::BUS_GUARD_S)) u_guard_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .en       (secTick),
    .clr      (!guardArmed || busTransaction),
    .tick     (guardTick)
  );

  // bus idle guard fires at most once per power arrival
  wire guardExpire = guardTick && guardArmed && !busTransaction;

  // scheduler
  wire pauseTick = (rateSel == tlc_pkg::RATE_MINUTE) ? minTick : secTick;
  wire oneShotEnd = (state_q == tlc_pkg::SCH_WAIT) && convDone &&
                    (rateSel == tlc_pkg::RATE_ONE_SHOT);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      tlc_pkg::SCH_IDLE:
        if (adcOn)
          state_d = tlc_pkg::SCH_START;
      tlc_pkg::SCH_START:
        state_d = tlc_pkg::SCH_WAIT;
      tlc_pkg::SCH_WAIT:
        if (convDone)
        begin
          unique case (rateSel)
            tlc_pkg::RATE_CONTINUOUS: state_d = tlc_pkg::SCH_START;
            tlc_pkg::RATE_ONE_SHOT:   state_d = tlc_pkg::SCH_IDLE;
            tlc_pkg::RATE_SECOND,
            tlc_pkg::RATE_MINUTE:     state_d = tlc_pkg::SCH_PAUSE;
          endcase
        end
      tlc_pkg::SCH_PAUSE:
        if (pauseTick)
          state_d = tlc_pkg::SCH_START;
      default:
        state_d = tlc_pkg::SCH_IDLE;
    endcase
    if (!adcOn)
      state_d = tlc_pkg::SCH_IDLE;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= tlc_pkg::SCH_IDLE;
      convStart_q <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      convStart_q <= (state_d == tlc_pkg::SCH_START);
    end
  end

  // threshold registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coldLimit_q <= tlc_pkg::COLD_LIMIT_RST;
      coolLimit_q <= tlc_pkg::COOL_LIMIT_RST;
      warmLimit_q <= tlc_pkg::WARM_LIMIT_RST;
      hotLimit_q  <= tlc_pkg::HOT_LIMIT_RST;
    end
    else if (regReset)
    begin
      coldLimit_q <= tlc_pkg::COLD_LIMIT_RST;
      coolLimit_q <= tlc_pkg::COOL_LIMIT_RST;
      warmLimit_q <= tlc_pkg::WARM_LIMIT_RST;
      hotLimit_q  <= tlc_pkg::HOT_LIMIT_RST;
    end
    else
    begin
      if (wrCold) coldLimit_q <= regWrData;
      if (wrCool) coolLimit_q <= regWrData;
      if (wrWarm) warmLimit_q <= regWrData;
      if (wrHot)  hotLimit_q  <= regWrData;
    end
  end

  // control registers; a host write beats the one-shot self clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlMain_q  <= tlc_pkg::CTRL_MAIN_RST;
      compSetup_q <= tlc_pkg::COMP_SETUP_RST;
    end
    else if (regReset)
    begin
      ctrlMain_q  <= tlc_pkg::CTRL_MAIN_RST;
      compSetup_q <= tlc_pkg::COMP_SETUP_RST;
    end
    else
    begin
      if (wrMain)
        ctrlMain_q <= mainWrMasked;
      else if (guardExpire || oneShotEnd)
        ctrlMain_q[tlc_pkg::ADC_ON_BIT] <= 1'b0;
      if (wrComp)
        compSetup_q <= compWrMasked;
    end
  end

  // guard bookkeeping: any transaction after power arrival disarms it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      guardServed_q    <= 1'b0;
      hwResetRequest_q <= 1'b0;
    end
    else
    begin
      hwResetRequest_q <= guardExpire;
      if (!inputPowerPresent)
        guardServed_q <= 1'b0;
      else if (busTransaction || guardExpire)
        guardServed_q <= 1'b1;
    end
  end

  // averaging of the thermistor result
  logic [15:0] filtResult;
  logic        filtValid;

  tlc_result_filter u_filter (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .avgOn         (averagingOn),
    .seedNew       (seedSelect),
    .sampleValid   (convDone && (state_q == tlc_pkg::SCH_WAIT)),
    .sampleData    (convData),
    .result_q      (filtResult),
    .resultValid_q (filtValid)
  );

  // limits scaled to result counts
  wire [15:0] coldScaled = 16'(coldLimit_q) << tlc_pkg::LIMIT_SCALE_SHIFT;
  wire [15:0] coolScaled = 16'(coolLimit_q) << tlc_pkg::LIMIT_SCALE_SHIFT;
  wire [15:0] warmScaled = 16'(warmLimit_q) << tlc_pkg::LIMIT_SCALE_SHIFT;
  wire [15:0] hotScaled  = 16'(hotLimit_q) << tlc_pkg::LIMIT_SCALE_SHIFT;

  // higher thermistor voltage means colder
  wire isCold = filtResult > coldScaled;
  wire isHot  = filtResult < hotScaled;
  wire isCool = (coolLimit_q != 8'h00) && !isCold &&
                (filtResult > coolScaled);
  wire isWarm = (warmLimit_q != 8'h00) && !isHot &&
                (filtResult < warmScaled);

  wire [3:0] effRes =
    (sampleSel == tlc_pkg::SAMPLE_FINE)   ? tlc_pkg::RES_FINE   :
    (sampleSel == tlc_pkg::SAMPLE_MEDIUM) ? tlc_pkg::RES_MEDIUM :
                                            tlc_pkg::RES_COARSE;

  // registered outputs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData_q            <= 8'h00;
      adcPowerOn_q           <= 1'b0;
      effResolution_q        <= tlc_pkg::RES_COARSE;
      comparatorOneOn_q      <= 1'b0;
      comparatorTwoOn_q      <= 1'b0;
      comparatorThreeOn_q    <= 1'b0;
      comparatorOneChannel_q <= 3'h0;
      auxInputBiasOn_q       <= 1'b0;
      thermistorResult_q     <= 16'h0000;
      resultValid_q          <= 1'b0;
      zoneCold_q             <= 1'b0;
      zoneCool_q             <= 1'b0;
      zoneWarm_q             <= 1'b0;
      zoneHot_q              <= 1'b0;
    end
    else
    begin
      if (regRdEn)
        regRdData_q <= rdMux;
      adcPowerOn_q           <= adcOn;
      effResolution_q        <= effRes;
      comparatorOneOn_q      <= compSetup_q[tlc_pkg::COMP_ONE_ON_BIT];
      comparatorTwoOn_q      <= compSetup_q[tlc_pkg::COMP_TWO_ON_BIT];
      comparatorThreeOn_q    <= compSetup_q[tlc_pkg::COMP_THREE_ON_BIT];
      comparatorOneChannel_q <= compSetup_q[tlc_pkg::COMP_ONE_CH_LSB +: 3];
      auxInputBiasOn_q       <= compSetup_q[tlc_pkg::AUX_BIAS_BIT];
      thermistorResult_q     <= filtResult;
      resultValid_q          <= filtValid;
      zoneCold_q             <= isCold;
      zoneCool_q             <= isCool;
      zoneWarm_q             <= isWarm;
      zoneHot_q              <= isHot;
    end
  end

endmodule : tlc_adc_ctrl

/* core/tlc_pkg.sv */
package tlc_pkg;

  // register offsets
  localparam logic [7:0] COLD_LIMIT_ADDR = 8'h14;
  localparam logic [7:0] COOL_LIMIT_ADDR = 8'h15;
  localparam logic [7:0] WARM_LIMIT_ADDR = 8'h16;
  localparam logic [7:0] HOT_LIMIT_ADDR  = 8'h17;
  localparam logic [7:0] CTRL_MAIN_ADDR  = 8'h18;
  localparam logic [7:0] COMP_SETUP_ADDR = 8'h19;

  // reset values
  localparam logic [7:0] COLD_LIMIT_RST = 8'h91;
  localparam logic [7:0] COOL_LIMIT_RST = 8'h00;
  localparam logic [7:0] WARM_LIMIT_RST = 8'h00;
  localparam logic [7:0] HOT_LIMIT_RST  = 8'h45;
  localparam logic [7:0] CTRL_MAIN_RST  = 8'h10;
  localparam logic [7:0] COMP_SETUP_RST = 8'hc8;

  // converter_control_main fields
  localparam int ADC_ON_BIT      = 7;
  localparam int RATE_LSB        = 5;
  localparam int SAMPLE_LSB      = 3;
  localparam int AVERAGING_BIT   = 2;
  localparam int SEED_SELECT_BIT = 1;

  // converter_comparator_setup fields
  localparam int COMP_ONE_ON_BIT   = 7;
  localparam int COMP_TWO_ON_BIT   = 6;
  localparam int COMP_THREE_ON_BIT = 5;
  localparam int COMP_ONE_CH_LSB   = 2;
  localparam int AUX_BIAS_BIT      = 1;

  // conversion rate codes
  localparam logic [1:0] RATE_CONTINUOUS = 2'h0;
  localparam logic [1:0] RATE_ONE_SHOT   = 2'h1;
  localparam logic [1:0] RATE_SECOND     = 2'h2;
  localparam logic [1:0] RATE_MINUTE     = 2'h3;

  // effective resolution per sample-speed code
  localparam logic [1:0] SAMPLE_FINE   = 2'h0;
  localparam logic [1:0] SAMPLE_MEDIUM = 2'h1;
  localparam logic [3:0] RES_FINE      = 4'hb;
  localparam logic [3:0] RES_MEDIUM    = 4'ha;
  localparam logic [3:0] RES_COARSE    = 4'h9;

  // one limit count is 4 mV, one result count is 0.25 mV: shift by 4
  localparam int LIMIT_SCALE_SHIFT = 4;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned SECOND_NS      = 1000000000;
  localparam int unsigned CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned MINUTE_S       = 60;
  localparam int unsigned BUS_GUARD_S    = 15;

  typedef enum logic [3:0] {
    SCH_IDLE  = 4'h1,
    SCH_START = 4'h2,
    SCH_WAIT  = 4'h4,
    SCH_PAUSE = 4'h8
  } tlc_sched_type;

endpackage : tlc_pkg

/* core/tlc_result_filter.sv */
module tlc_result_filter (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // settings
  input  wire logic        avgOn,
  input  wire logic        seedNew,
  // fresh conversion
  input  wire logic        sampleValid,
  input  wire logic [15:0] sampleData,
  // result register
  output logic [15:0]      result_q,
  output logic             resultValid_q
);

  logic        primed_q;
  wire  [16:0] sum = {1'b0, result_q} + {1'b0, sampleData};
  wire         takeRaw = !avgOn || (!primed_q && seedNew);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_q      <= 16'h0000;
      resultValid_q <= 1'b0;
      primed_q      <= 1'b0;
    end
    else
    begin
      resultValid_q <= sampleValid;
      // leaving averaging forgets the seed so the next start reseeds
      if (!avgOn)
        primed_q <= 1'b0;
      else if (sampleValid)
        primed_q <= 1'b1;
      if (sampleValid)
        result_q <= takeRaw ? sampleData : sum[16:1];
    end
  end

endmodule : tlc_result_filter

/* core/tlc_tick_divider.sv */
module tlc_tick_divider #(
  parameter int unsigned DIV = 2
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // control
  input  wire logic en,
  input  wire logic clr,
  // one-cycle tick every DIV enabled cycles
  output logic      tick
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;
  wire          atLast = (cnt_q == LAST);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick <= en && !clr && atLast;
      if (clr || (en && atLast))
        cnt_q <= '0;
      else if (en)
        cnt_q <= cnt_q + W'(1);
    end
  end

endmodule : tlc_tick_divider

/* sim/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SEC = 8;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regReset = 1'b0;
  logic        busTransaction = 1'b0;
  logic        busIdleGuardOn = 1'b0;
  logic        inputPowerPresent = 1'b1;
  logic [7:0]  lat = 8'h00;
  logic [15:0] sample = 16'h0000;
  logic [7:0]  regRdData_q;
  logic [3:0]  effResolution_q;
  logic [2:0]  comparatorOneChannel_q;
  logic [15:0] convData, thermistorResult_q;
  logic        hwResetRequest_q, adcPowerOn_q, convStart_q, convDone, resultValid_q;
  logic        comparatorOneOn_q, comparatorTwoOn_q, comparatorThreeOn_q, auxInputBiasOn_q;
  logic        zoneCold_q, zoneCool_q, zoneWarm_q, zoneHot_q;
  int          n_errors = 0;
  int          checked = 0;

  always #2.5 core_clk = ~core_clk;

  tlc_adc_ctrl #(.SEC_CYCLES(SEC)) u_tlc_adc_ctrl (
    .core_clk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_q,
    .regReset, .busTransaction, .busIdleGuardOn, .inputPowerPresent,
    .hwResetRequest_q, .adcPowerOn_q, .convStart_q, .convDone, .convData,
    .effResolution_q, .comparatorOneOn_q, .comparatorTwoOn_q, .comparatorThreeOn_q,
    .comparatorOneChannel_q, .auxInputBiasOn_q, .thermistorResult_q, .resultValid_q,
    .zoneCold_q, .zoneCool_q, .zoneWarm_q, .zoneHot_q
  );
  tlc_conv_model u_tlc_conv_model (
    .core_clk, .rst_n, .convStart_q, .convDone, .convData, .lat, .sample
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // strobe, then one idle edge so back-to-back calls never re-raise it at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge core_clk);
    #1 regWrEn = 1'b0;
    @(posedge core_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #1 regRdEn = 1'b0;
    d = regRdData_q;
    @(posedge core_clk);
    #1;
  endtask : rd

  task automatic comps(input logic [15:0] exp);
    chk("comparators", exp, {9'h000, comparatorOneOn_q, comparatorTwoOn_q,
        comparatorThreeOn_q, comparatorOneChannel_q, auxInputBiasOn_q});
  endtask : comps

  task automatic t_dflt();
    logic [7:0] rv [6] = '{8'h91, 8'h00, 8'h00, 8'h45, 8'h10, 8'hc8};
    logic [7:0] d;
    for (int k = 0; k < 6; k++)
    begin
      rd(8'h14 + 8'(k), d);
      chk("register", {8'h00, rv[k]}, {8'h00, d});
    end
    chk("resolution", 16'h0009, {12'h000, effResolution_q});
    comps(16'h0064);
    $display("test defaults done");
  endtask : t_dflt

  task automatic t_field();
    logic [3:0] res [4] = '{4'hb, 4'ha, 4'h9, 4'h9};
    logic [7:0] d;
    wr(8'h14, 8'hff);
    rd(8'h14, d);
    chk("cold limit", 16'h00ff, {8'h00, d});
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h18, 8'(k << 3));
      chk("resolution", {12'h000, res[k]}, {12'h000, effResolution_q});
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h19, 8'(k << 2));
      comps(16'(k << 1));
    end
    wr(8'h19, 8'hff);
    rd(8'h19, d);
    chk("setup", 16'h00fe, {8'h00, d});
    comps(16'h007f);
    wr(8'h1a, 8'hff);
    rd(8'h1a, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    wr(8'h14, 8'h91);
    $display("test fields done");
  endtask : t_field

  // one-shot conversion, then result, zone and self-cleared on bit
  task automatic conv(input logic [7:0] c, input logic [15:0] s, input logic [15:0] r,
                      input logic [3:0] z);
    int i;
    logic [7:0] d;
    sample = s;
    wr(8'h18, c);
    i = 0;
    while (resultValid_q !== 1'b1 && i < 100)
    begin
      @(posedge core_clk);
      #1 i++;
    end
    chk("result", r, thermistorResult_q);
    @(posedge core_clk);
    #1 chk("zone", {12'h000, z}, {12'h000, zoneCold_q, zoneCool_q, zoneWarm_q, zoneHot_q});
    rd(8'h18, d);
    chk("one-shot", {8'h00, c & 8'h7e}, {8'h00, d});
  endtask : conv

  task automatic t_zone();
    conv(8'ha0, 16'h0880, 16'h0880, 4'h0);
    wr(8'h15, 8'h80);
    wr(8'h16, 8'h60);
    lat = 8'h14;
    conv(8'ha0, 16'h0880, 16'h0880, 4'h4);
    lat = 8'h02;
    conv(8'ha0, 16'h0500, 16'h0500, 4'h2);
    conv(8'ha0, 16'h0400, 16'h0400, 4'h1);
    conv(8'ha0, 16'h0a00, 16'h0a00, 4'h8);
    conv(8'ha4, 16'h0200, 16'h0600, 4'h0);
    conv(8'ha0, 16'h0300, 16'h0300, 4'h1);
    conv(8'ha6, 16'h0200, 16'h0200, 4'h1);
    conv(8'ha6, 16'h0400, 16'h0300, 4'h1);
    $display("test zones done");
  endtask : t_zone

  task automatic nxt(output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1 n++;
    end
    while (convStart_q !== 1'b1 && n < 600);
  endtask : nxt

  task automatic gap(input logic [7:0] c, input int exp);
    int n;
    wr(8'h18, c);
    nxt(n);
    nxt(n);
    nxt(n);
    chk("start spacing", 16'(exp), 16'(n));
  endtask : gap

  task automatic t_rate();
    int n;
    lat = 8'h01;
    gap(8'hc0, SEC);
    gap(8'he0, 60 * SEC);
    // restart follows done by one edge: model takes lat + 2 edges after a start
    gap(8'h80, int'(lat) + 3);
    wr(8'h18, 8'h00);
    nxt(n);
    chk("no start when off", 16'd600, 16'(n));
    $display("test rates done");
  endtask : t_rate

  task automatic hw_wait(output int n);
    n = 0;
    while (hwResetRequest_q !== 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask : hw_wait

  task automatic t_guard();
    int n;
    logic [7:0] d;
    busIdleGuardOn = 1'b1;
    inputPowerPresent = 1'b0;
    wr(8'h18, 8'h80);
    inputPowerPresent = 1'b1;
    hw_wait(n);
    chk("guard expiry", 16'h0001, {15'h0000, n >= 14 * SEC && n <= 15 * SEC + 3});
    rd(8'h18, d);
    chk("on bit", 16'h0000, {15'h0000, d[7]});
    inputPowerPresent = 1'b0;
    @(posedge core_clk);
    #1 inputPowerPresent = 1'b1;
    repeat (40) @(posedge core_clk);
    #1 busTransaction = 1'b1;
    @(posedge core_clk);
    #1 busTransaction = 1'b0;
    hw_wait(n);
    chk("guard disarmed", 16'd200, 16'(n));
    busIdleGuardOn = 1'b0;
    $display("test guard done");
  endtask : t_guard

  task automatic t_rrst();
    wr(8'h14, 8'h00);
    wr(8'h19, 8'h00);
    wr(8'h18, 8'h9c);
    regAddr = 8'h17;
    regWrData = 8'h00;
    regWrEn = 1'b1;
    regReset = 1'b1;
    @(posedge core_clk);
    #1 regWrEn = 1'b0;
    regReset = 1'b0;
    @(posedge core_clk);
    #1 t_dflt();
    $display("test register reset done");
  endtask : t_rrst

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  initial
  begin
    #100000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk);
    #1 t_dflt();
    t_field();
    t_zone();
    t_rate();
    t_guard();
    t_rrst();
    finish_test();
  end
endmodule : tb_top

/* sim/tlc_adc_ctrl_asserts.sv */
module tlc_adc_ctrl_asserts (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register port
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData_q,
  input wire logic        regReset,
  // converter and status
  input wire logic        hwResetRequest_q,
  input wire logic        adcPowerOn_q,
  input wire logic        convStart_q,
  input wire logic        convDone,
  input wire logic [15:0] convData,
  input wire logic [3:0]  effResolution_q,
  input wire logic        comparatorOneOn_q,
  input wire logic [15:0] thermistorResult_q,
  input wire logic        resultValid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic wrMain;
  logic avgOn_q;
  assign wrMain = regWrEn && !regReset && regAddr == 8'h18;
  // mirror of the averaging bit, so the result check knows the mode
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      avgOn_q <= 1'b0;
    else if (regReset)
      avgOn_q <= 1'b0;
    else if (wrMain)
      avgOn_q <= regWrData[2];
  end
  property p_on;
    wrMain && regWrData[7] |=> ##1 adcPowerOn_q;
  endproperty
  a_on: assert property (p_on) else $error("converter not on after enable");
  property p_off;
    wrMain && !regWrData[7] |=> ##1 !adcPowerOn_q;
  endproperty
  a_off: assert property (p_off) else $error("converter on after disable");
  property p_res11;
    wrMain && regWrData[4:3] == 2'h0 |=> ##1 effResolution_q == 4'hb;
  endproperty
  a_res11: assert property (p_res11) else $error("resolution not 11");
  property p_res9;
    wrMain && regWrData[4] |=> ##1 effResolution_q == 4'h9;
  endproperty
  a_res9: assert property (p_res9) else $error("resolution not 9");
  property p_rsv;
    regRdEn && (regAddr == 8'h18 || regAddr == 8'h19) |=> !regRdData_q[0];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
  property p_valid;
    resultValid_q |-> $past(convDone, 2);
  endproperty
  a_valid: assert property (p_valid) else $error("result without done");
  property p_latest;
    resultValid_q && !$past(avgOn_q, 2) |-> thermistorResult_q == $past(convData, 2);
  endproperty
  a_latest: assert property (p_latest) else $error("result not latest");
  property p_wdclr;
    hwResetRequest_q |=> !adcPowerOn_q;
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("on bit kept on expiry");
  property p_wdpulse;
    hwResetRequest_q |=> !hwResetRequest_q;
  endproperty
  a_wdpulse: assert property (p_wdpulse) else $error("reset request too long");
  property p_start;
    convStart_q |=> !convStart_q;
  endproperty
  a_start: assert property (p_start) else $error("start pulse too long");
  property p_rst16;
    regReset |=> ##1 comparatorOneOn_q && effResolution_q == 4'h9;
  endproperty
  a_rst16: assert property (p_rst16) else $error("defaults not restored");
  c_valid: cover property (resultValid_q);
  c_guard: cover property (hwResetRequest_q);
  c_reset: cover property (regReset);
endmodule : tlc_adc_ctrl_asserts

bind tlc_adc_ctrl tlc_adc_ctrl_asserts u_tlc_adc_ctrl_asserts (
  .core_clk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_q,
  .regReset, .hwResetRequest_q, .adcPowerOn_q, .convStart_q, .convDone, .convData,
  .effResolution_q, .comparatorOneOn_q, .thermistorResult_q, .resultValid_q
);

/* sim/tlc_conv_model.sv */
module tlc_conv_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // converter link
  input  wire logic        convStart_q,
  output logic             convDone,
  output logic [15:0]      convData,
  // latency and value chosen by the bench
  input  wire logic [7:0]  lat,
  input  wire logic [15:0] sample
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic       busy;
  // data is only good with done; inverted every cycle otherwise so nothing leans on it
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy     <= 1'b0;
      cnt      <= 8'h00;
      convDone <= 1'b0;
      convData <= 16'h0000;
    end
    else
    begin
      convDone <= 1'b0;
      convData <= ~convData;
      if (convStart_q)
      begin
        busy <= 1'b1;
        cnt  <= lat;
      end
      else if (busy && cnt == 8'h00)
      begin
        busy     <= 1'b0;
        convDone <= 1'b1;
        convData <= sample;
      end
      else if (busy)
        cnt <= cnt - 8'h01;
    end
  end
endmodule : tlc_conv_model
